// ===== verification/spl_link_bench.sv
// Purpose: Self-checking master role run of spl_link
// Assumes: Slave stand-in returns ones
// Notes:   Slave role left to a later run
module spl_link_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, rd_d = 1'b0;
	logic c_d = 1'b1, cpha = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] wd = 32'h0000_0000;
	logic [31:0] rdata, cap;
	logic sclk, sclk_oe, cs_n, cs_oe, mosi, mosi_oe, miso, miso_oe, s_miso;
	logic [31:0] rq[$];
	logic [31:0] cq[$];
	int error_cnt = 0;
	int n_compared = 0;
	int lens[7] = '{8, 8, 5, 3, 12, 32, 16};
	logic [31:0] fl[7] = '{32'h0000_0010, 32'h0000_00F3, 32'h0000_0000,
		32'h0000_002B, 32'h000C_0030, 32'h0000_0050, 32'h0000_0093};
	always #4 clk = !clk;
	spl_link spl_link_i (.clk_sys_in(clk), .rst_n_in(rst_n),
		.reg_addr_in(adr), .reg_wdata_in(wd), .reg_wr_in(wr),
		.reg_rd_in(rd), .reg_rdata_out(rdata),
		.sclk_pin_in(sclk_oe ? sclk : 1'b0), .sclk_out(sclk),
		.sclk_oe_out(sclk_oe), .cs_n_pin_in(cs_oe ? cs_n : 1'b1),
		.cs_n_out(cs_n), .cs_n_oe_out(cs_oe),
		.mosi_pin_in(mosi_oe ? mosi : 1'b0), .mosi_out(mosi),
		.mosi_oe_out(mosi_oe), .miso_pin_in(miso_oe ? miso : s_miso),
		.miso_out(miso), .miso_oe_out(miso_oe));
	spl_slave_model spl_slave_model_i (.clk_sys_in(clk), .sclk_in(sclk),
		.cs_n_in(cs_n), .mosi_in(mosi), .cpha_in(cpha),
		.miso_out(s_miso), .cap_out(cap));
	task automatic tally_and_finish();
		if (error_cnt == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk(string n, logic [31:0] x, logic [31:0] y);
		n_compared++;
		if (x !== y) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", n, x, y);
		end
	endtask
	task automatic bus(logic r, logic [7:0] a, logic [31:0] d,
		logic [31:0] x);
		if (r)
			rq.push_back(x);
		adr <= a;
		wd <= d;
		wr <= !r;
		rd <= r;
		@(posedge clk);
		wr <= 1'b0;
		rd <= 1'b0;
		@(posedge clk);
	endtask
	// Mode 0 waits select low, 1 select high, 2 full capture
	task automatic hold(int k, logic [31:0] x);
		int i;
		for (i = 0; i < 4000; i++) begin
			@(posedge clk);
			if (k == 0 ? cs_n === 1'b0 : k == 1 ? cs_n === 1'b1 : cap === x)
				break;
		end
		if (i == 4000) begin
			error_cnt++;
			tally_and_finish();
		end
	endtask
	function automatic logic [31:0] bsw(logic [31:0] x);
		return {x[7:0], x[15:8], x[23:16], x[31:24]};
	endfunction
	function automatic logic [63:0] model(logic [31:0] x, int l,
		logic [31:0] c);
		logic [31:0] v, m, cp, rx;
		int u;
		u = l <= 8 ? 8 : l <= 16 ? 16 : 32;
		m = 32'hFFFF_FFFF >> (32 - l);
		cp = 32'h0000_0000;
		rx = 32'h0000_0000;
		x = c[6] ? bsw(x) : x;
		for (int k = 0; k < 32 / u; k++) begin
			v = (x >> (k * u)) & m;
			rx |= (c[4] ? v : m) << (k * u);
			for (int j = 0; j < l; j++)
				cp = {cp[30:0], v[c[5] ? j : l - 1 - j]};
		end
		rx = c[3] ? 32'h0000_0000 : c[7] ? bsw(rx) : rx;
		return {cp, rx};
	endfunction
	always @(posedge clk) begin
		rd_d <= rd;
		c_d <= cs_n;
		if (rd_d)
			chk("read data", rq.pop_front(), rdata);
		if (cs_n === 1'b1 && c_d === 1'b0)
			chk("slave capture", cq.pop_front(), cap);
	end
	initial begin
		logic [63:0] e;
		logic [31:0] c, d, w;
		int l;
		w = $urandom(32'hd1a6);
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		bus(1, spl_pkg::ADDR_CONFIG1, 0, spl_pkg::RST_CONFIG1);
		bus(1, spl_pkg::ADDR_CLK_DIV, 0, spl_pkg::RST_CLK_DIV);
		bus(1, 8'h40, 0, 32'h0000_0000);
		for (int k = 0; k < 7; k++) begin
			l = lens[k];
			c = fl[k] | 32'h0000_0004 | 32'(l) << 12
				| 32'(l <= 8 ? 4 : l <= 16 ? 2 : 1) << 20;
			w = $urandom;
			d = 2 + $urandom % 4;
			e = model(w, l, c);
			cpha <= c[0];
			bus(0, spl_pkg::ADDR_CLK_DIV, d, 0);
			bus(1, spl_pkg::ADDR_CLK_DIV, 0, d);
			bus(0, spl_pkg::ADDR_CONFIG1, c, 0);
			bus(1, spl_pkg::ADDR_CONFIG1, 0, c);
			cq.push_back(e[63:32]);
			bus(0, spl_pkg::ADDR_TX_DATA, w, 0);
			hold(0, 0);
			if (c[18]) begin
				hold(2, e[63:32]);
				chk("select held", 32'h0000_0000, {31'h0, cs_n});
				bus(0, spl_pkg::ADDR_CONFIG1, c & 32'hFFF7_FFFF, 0);
			end
			hold(1, 0);
			// Last bytes still drain into the store after select
			repeat (4) @(posedge clk);
			bus(1, spl_pkg::ADDR_RX_DATA, 0, e[31:0]);
		end
		tally_and_finish();
	end
endmodule // spl_link_bench
bind spl_link spl_link_sva spl_link_sva_i (.clk_sys_in(clk_sys_in),
	.rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in),
	.reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
	.sclk_out(sclk_out), .sclk_oe_out(sclk_oe_out), .cs_n_out(cs_n_out),
	.cs_n_oe_out(cs_n_oe_out), .mosi_out(mosi_out));

// ===== verification/spl_link_sva.sv
// Purpose: Port checks of spl_link in master role
// Assumes: Config is shadowed from register writes
// Notes:   Slave role watched only for its clock and select enables
module spl_link_sva (
	input wire logic        clk_sys_in,
	input wire logic        rst_n_in,
	input wire logic [7:0]  reg_addr_in,
	input wire logic [31:0] reg_wdata_in,
	input wire logic        reg_wr_in,
	input wire logic        sclk_out,
	input wire logic        sclk_oe_out,
	input wire logic        cs_n_out,
	input wire logic        cs_n_oe_out,
	input wire logic        mosi_out
);
	logic [31:0] cfg_ff, nxt_cfg;
	logic [1:0]  q_ff, nxt_q;
	logic        cw;
	assign cw = reg_wr_in && reg_addr_in == spl_pkg::ADDR_CONFIG1;
	// Quiet count gives the pins time to follow a config write
	always_comb begin
		nxt_cfg = cw ? reg_wdata_in & spl_pkg::CONFIG1_MASK : cfg_ff;
		nxt_q = (cw || !cs_n_out) ? 2'h0 : q_ff + {1'b0, q_ff != 2'h3};
	end
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cfg_ff <= spl_pkg::RST_CONFIG1;
			q_ff   <= 2'h0;
		end else begin
			cfg_ff <= nxt_cfg;
			q_ff   <= nxt_q;
		end
	end
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (!rst_n_in);
	a_sclk_idle: assert property (q_ff == 2'h3 && cs_n_out |-> sclk_out == cfg_ff[1])
		else $error("sclk idle level");
	a_sclk_role: assert property (q_ff == 2'h3 |-> sclk_oe_out == cfg_ff[2])
		else $error("sclk enable vs role");
	a_cs_role: assert property (q_ff == 2'h3 |-> cs_n_oe_out == cfg_ff[2])
		else $error("select enable vs role");
	a_cs_master: assert property (!cs_n_out |-> cs_n_oe_out && sclk_oe_out)
		else $error("select without master drive");
	a_sample_stable: assert property (!cs_n_out && $past(!cs_n_out) && $changed(sclk_out) && sclk_out != cfg_ff[0] |-> $stable(mosi_out))
		else $error("data moved on sample edge");
	a_stream_hold: assert property (!cs_n_out && cfg_ff[18] && cfg_ff[19] && !cw |=> !cs_n_out)
		else $error("stream select dropped");
	a_go_stop: assert property ($fell(cfg_ff[19]) |-> ##[0:8] cs_n_out)
		else $error("select held after go cleared");
	a_no_start: assert property (cs_n_out && (cfg_ff[18] ? !cfg_ff[19] : cfg_ff[8]) |=> cs_n_out)
		else $error("transfer started while held off");
endmodule // spl_link_sva

// ===== verification/spl_slave_model.sv
// Purpose: Serial slave stand-in for master role runs
// Assumes: Serial clock slower than the system clock
// Notes:   Answers ones; released line toggles
module spl_slave_model (
	input wire logic    clk_sys_in,
	input wire logic    sclk_in,
	input wire logic    cs_n_in,
	input wire logic    mosi_in,
	input wire logic    cpha_in,
	output logic        miso_out,
	output logic [31:0] cap_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic s_d = 1'b0;
	logic c_d = 1'b1;
	logic tog = 1'b0;
	// Deselected line must not show a stale level
	assign miso_out = cs_n_in ? tog : 1'b1;
	always @(posedge clk_sys_in) begin
		s_d <= sclk_in;
		c_d <= cs_n_in;
		tog <= !tog;
		if (c_d && !cs_n_in)
			cap_out <= 32'h0000_0000;
		else if (!cs_n_in && sclk_in != s_d && sclk_in == !cpha_in)
			cap_out <= {cap_out[30:0], mosi_in};
	end
endmodule // spl_slave_model

// ===== verilog/spl_fifo.sv
// Purpose: Word store with registered show-ahead head
// Assumes: Push when full and pop when empty are ignored
// Notes:   DEPTH must be a power of two
module spl_fifo #(
	parameter int W     = 32,
	parameter int DEPTH = 8,
	parameter int AW    = 3
) (
	input  wire logic  clk_in,
	input  wire logic  rst_n_in,
	spl_fifo_if.store  fifo_port
);
	logic [W-1:0]  mem [DEPTH];
	logic [AW-1:0] wr_ptr_ff,  nxt_wr_ptr_ff;
	logic [AW-1:0] rd_ptr_ff,  nxt_rd_ptr_ff;
	logic [AW:0]   count_ff,   nxt_count_ff;
	logic [W-1:0]  head_ff,    nxt_head_ff;
	logic          push_ok;
	logic          pop_ok;

	assign fifo_port.head  = head_ff;
	assign fifo_port.empty = (count_ff == '0);
	assign fifo_port.full  = (count_ff == (AW+1)'(DEPTH));

	always_comb begin
		push_ok       = fifo_port.push && !fifo_port.full;
		pop_ok        = fifo_port.pop && !fifo_port.empty;
		nxt_wr_ptr_ff = push_ok ? wr_ptr_ff + 1'b1 : wr_ptr_ff;
		nxt_rd_ptr_ff = pop_ok ? rd_ptr_ff + 1'b1 : rd_ptr_ff;
		nxt_count_ff  = count_ff + (AW+1)'(push_ok) - (AW+1)'(pop_ok);
		// Bypass so a word pushed into the head slot shows at once
		if (push_ok && wr_ptr_ff == nxt_rd_ptr_ff) begin
			nxt_head_ff = fifo_port.wdata;
		end else begin
			nxt_head_ff = mem[nxt_rd_ptr_ff];
		end
	end

	always_ff @(posedge clk_in) begin
		if (push_ok) begin
			mem[wr_ptr_ff] <= fifo_port.wdata;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			count_ff  <= '0;
			head_ff   <= '0;
		end else begin
			wr_ptr_ff <= nxt_wr_ptr_ff;
			rd_ptr_ff <= nxt_rd_ptr_ff;
			count_ff  <= nxt_count_ff;
			head_ff   <= nxt_head_ff;
		end
	end
endmodule // spl_fifo

// ===== verilog/spl_fifo_if.sv
// Purpose: Push/pop carrier between the link core and its word stores
// Assumes: Single clock
// Notes:   Head is a registered show-ahead word
interface spl_fifo_if #(parameter int W = 32);
	logic         push;
	logic [W-1:0] wdata;
	logic         pop;
	logic [W-1:0] head;
	logic         empty;
	logic         full;
	modport store (input push, input wdata, input pop,
		output head, output empty, output full);
	modport user (output push, output wdata, output pop,
		input head, input empty, input full);
endinterface

// ===== verilog/spl_link.sv
// Purpose: Serial link controller, configuration and datapath
// Assumes: Slave serial clock at most clk_sys_in / 8
// Notes:   Partial receive words wait in the packer until 4 bytes
// Notes on behaviour
// RULE_01: Stream go starts transfer once transmit data present
// RULE_02: Clearing go drops chip select, halts stream
// RULE_03: Software drains transmit store before stopping stream
// RULE_04: Software loads 8/16/32-bit units covering length
// RULE_05: Stream enable selects go-controlled continuous streaming
// RULE_06: Six-bit length field, 3 to 32, default 8
// RULE_07: Received words zero-padded to 8/16/32 bits
// RULE_08: Transmit pops 8/16/32 bits, drops extra bits
// RULE_09: Transmit disable stops draining; resets disabled
// RULE_10: Receive swap reverses bytes on 32-bit reads
// RULE_11: Transmit swap reverses bytes on 32-bit writes
// RULE_12: Bit order: zero MSB first, one LSB first
// RULE_13: Loopback routes transmit bit into receive path
// RULE_14: Receive disable stops pushes into receive store
// RULE_15: Role bit: zero slave, one master
// RULE_16: Idle serial clock level follows polarity bit
// RULE_17: Phase picks drive and sample clock edges
// RULE_18: Full duplex: one bit each way per clock
// RULE_19: Master clock divides system clock, divisor min 2
// RULE_20: Count sets transactions per chip select, data-gated
// RULE_21: Stream mode holds chip select until go cleared
//
// Implementation choices: the strobed register port and the placing of the registers.
module spl_link #(
	parameter int DEPTH = 8,
	parameter int AW    = 3
) (
	input  wire logic        clk_sys_in,
	input  wire logic        rst_n_in,
	input  wire logic [7:0]  reg_addr_in,
	input  wire logic [31:0] reg_wdata_in,
	input  wire logic        reg_wr_in,
	input  wire logic        reg_rd_in,
	output logic      [31:0] reg_rdata_out,
	input  wire logic        sclk_pin_in,
	output logic             sclk_out,
	output logic             sclk_oe_out,
	input  wire logic        cs_n_pin_in,
	output logic             cs_n_out,
	output logic             cs_n_oe_out,
	input  wire logic        mosi_pin_in,
	output logic             mosi_out,
	output logic             mosi_oe_out,
	input  wire logic        miso_pin_in,
	output logic             miso_out,
	output logic             miso_oe_out
);
	logic [1:0]  rst_sync_ff;
	logic        rst_n;
	logic        sclk_s1_ff, sclk_s2_ff, sclk_s3_ff;
	logic        cs_s1_ff,   cs_s2_ff,   cs_s3_ff;
	logic        mosi_s1_ff, mosi_s2_ff;
	logic        miso_s1_ff, miso_s2_ff;
	logic [31:0] clk_div_ff,   nxt_clk_div_ff;
	logic [31:0] cfg_ff,       nxt_cfg_ff;
	logic [31:0] rdata_ff,     nxt_rdata_ff;
	logic        tx_ovf_ff,    nxt_tx_ovf_ff;
	logic        rx_ovf_ff,    nxt_rx_ovf_ff;
	spl_pkg::spl_state_t state_ff, nxt_state_ff;
	logic [31:0] asm_ff,       nxt_asm_ff;
	logic [31:0] rx_word_ff,   nxt_rx_word_ff;
	logic [2:0]  byte_idx_ff,  nxt_byte_idx_ff;
	logic [5:0]  bit_cnt_ff,   nxt_bit_cnt_ff;
	logic [5:0]  out_cnt_ff,   nxt_out_cnt_ff;
	logic [31:0] div_cnt_ff,   nxt_div_cnt_ff;
	logic        sclk_ff,      nxt_sclk_ff;
	logic        cs_n_ff,      nxt_cs_n_ff;
	logic        txbit_ff,     nxt_txbit_ff;
	logic [7:0]  txn_left_ff,  nxt_txn_left_ff;
	logic [31:0] tx_word_ff,   nxt_tx_word_ff;
	logic [2:0]  tx_left_ff,   nxt_tx_left_ff;
	logic [31:0] drain_ff,     nxt_drain_ff;
	logic [2:0]  drain_left_ff, nxt_drain_left_ff;
	logic [23:0] pack_ff,      nxt_pack_ff;
	logic [1:0]  pack_fill_ff, nxt_pack_fill_ff;
	logic        master_oe_ff, nxt_master_oe_ff;
	logic        miso_oe_ff,   nxt_miso_oe_ff;
	logic        master, stream_en, stream_go, tx_dis, rx_dis;
	logic        lsb_first, loop_en, cpol, cpha;
	logic [5:0]  len_raw, len_eff;
	logic [2:0]  nbytes;
	logic [31:0] div_eff, half;
	logic        tick, edge_ev, lvl, is_sample, is_drive, rx_bit;
	logic        byte_av, data_ok, cs_act_s;
	logic        handoff_c, drop_c;
	logic [7:0]  status;

	spl_fifo_if #(.W(32)) tx_f ();
	spl_fifo_if #(.W(32)) rx_f ();

	spl_fifo #(.W(32), .DEPTH(DEPTH), .AW(AW)) u_tx_store (
		.clk_in    (clk_sys_in),
		.rst_n_in  (rst_n),
		.fifo_port (tx_f.store)
	);
	spl_fifo #(.W(32), .DEPTH(DEPTH), .AW(AW)) u_rx_store (
		.clk_in    (clk_sys_in),
		.rst_n_in  (rst_n),
		.fifo_port (rx_f.store)
	);

	function automatic logic [31:0] bswap(input logic [31:0] w);
		return {w[7:0], w[15:8], w[23:16], w[31:24]};
	endfunction

	function automatic logic [4:0] bit_pos(input logic [5:0] n,
		input logic [5:0] len, input logic lsb);
		logic [5:0] p;
		p = lsb ? n : len - 6'h01 - n;
		return p[4:0];
	endfunction

	// Release reset through two flops
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rst_sync_ff <= 2'b00;
		end else begin
			rst_sync_ff <= {rst_sync_ff[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_ff[1];

	// Pin synchronisers; third clock stage only feeds edge detection
	always_ff @(posedge clk_sys_in or negedge rst_n) begin
		if (!rst_n) begin
			{sclk_s1_ff, sclk_s2_ff, sclk_s3_ff} <= 3'b000;
			{cs_s1_ff, cs_s2_ff, cs_s3_ff}       <= 3'b111;
			{mosi_s1_ff, mosi_s2_ff}             <= 2'b00;
			{miso_s1_ff, miso_s2_ff}             <= 2'b00;
		end else begin
			{sclk_s1_ff, sclk_s2_ff, sclk_s3_ff} <=
				{sclk_pin_in, sclk_s1_ff, sclk_s2_ff};
			{cs_s1_ff, cs_s2_ff, cs_s3_ff} <=
				{cs_n_pin_in, cs_s1_ff, cs_s2_ff};
			{mosi_s1_ff, mosi_s2_ff} <= {mosi_pin_in, mosi_s1_ff};
			{miso_s1_ff, miso_s2_ff} <= {miso_pin_in, miso_s1_ff};
		end
	end

	// Decoded configuration
	always_comb begin
		master    = cfg_ff[spl_pkg::BIT_ROLE]; // see RULE_15
		stream_en = cfg_ff[spl_pkg::BIT_STREAM_EN]; // see RULE_05
		stream_go = cfg_ff[spl_pkg::BIT_STREAM_GO];
		tx_dis    = cfg_ff[spl_pkg::BIT_TX_DIS];
		rx_dis    = cfg_ff[spl_pkg::BIT_RX_DIS];
		lsb_first = cfg_ff[spl_pkg::BIT_LSB_FIRST];
		loop_en   = cfg_ff[spl_pkg::BIT_LOOP];
		cpol      = cfg_ff[spl_pkg::BIT_CPOL];
		cpha      = cfg_ff[spl_pkg::BIT_CPHA];
		len_raw   = cfg_ff[spl_pkg::LEN_HI:spl_pkg::LEN_LO];
		// Out-of-range lengths are clamped rather than trusted
		if (len_raw < spl_pkg::LEN_MIN) begin // see RULE_06
			len_eff = spl_pkg::LEN_MIN;
		end else if (len_raw > spl_pkg::LEN_MAX) begin
			len_eff = spl_pkg::LEN_MAX;
		end else begin
			len_eff = len_raw;
		end
		// Byte span per transaction, 1, 2 or 4
		if (len_eff <= 6'h08) begin // see RULE_08
			nbytes = 3'h1;
		end else if (len_eff <= 6'h10) begin
			nbytes = 3'h2;
		end else begin
			nbytes = spl_pkg::WORD_BYTES;
		end
		div_eff = (clk_div_ff < spl_pkg::DIV_MIN) ?
			spl_pkg::DIV_MIN : clk_div_ff; // see RULE_19
		half     = {1'b0, div_eff[31:1]};
		tick     = (div_cnt_ff == half - 32'h0000_0001) ||
			(div_cnt_ff == div_eff - 32'h0000_0001);
		cs_act_s = !cs_s2_ff;
		byte_av  = (tx_left_ff != 3'h0) || !tx_f.empty;
		data_ok  = tx_dis || byte_av;
		if (master) begin
			edge_ev = (state_ff == spl_pkg::ST_SHIFT) && tick;
			lvl     = !sclk_ff;
		end else begin
			edge_ev = (state_ff == spl_pkg::ST_SHIFT) &&
				(sclk_s2_ff != sclk_s3_ff);
			lvl     = sclk_s2_ff;
		end
		is_sample = edge_ev && (lvl != cpha); // see RULE_17
		is_drive  = edge_ev && (lvl == cpha);
		if (loop_en) begin // see RULE_13
			rx_bit = txbit_ff;
		end else begin
			rx_bit = master ? miso_s2_ff : mosi_s2_ff;
		end
	end

	// Transfer engine
	always_comb begin
		nxt_state_ff    = state_ff;
		nxt_asm_ff      = asm_ff;
		nxt_rx_word_ff  = rx_word_ff;
		nxt_byte_idx_ff = byte_idx_ff;
		nxt_bit_cnt_ff  = bit_cnt_ff;
		nxt_out_cnt_ff  = out_cnt_ff;
		nxt_div_cnt_ff  = div_cnt_ff;
		nxt_sclk_ff     = sclk_ff;
		nxt_cs_n_ff     = cs_n_ff;
		nxt_txn_left_ff = txn_left_ff;
		nxt_tx_word_ff  = tx_word_ff;
		nxt_tx_left_ff  = tx_left_ff;
		tx_f.pop        = 1'b0;
		handoff_c       = 1'b0;
		drop_c          = 1'b0;
		case (state_ff)
			spl_pkg::ST_IDLE: begin
				nxt_sclk_ff     = cpol; // see RULE_16
				nxt_cs_n_ff     = 1'b1;
				nxt_byte_idx_ff = 3'h0;
				nxt_asm_ff      = 32'h0000_0000;
				nxt_txn_left_ff = (cfg_ff[spl_pkg::CNT_HI:spl_pkg::CNT_LO]
					== 8'h00) ? 8'h01 :
					cfg_ff[spl_pkg::CNT_HI:spl_pkg::CNT_LO];
				if (master) begin
					if (stream_en ? (stream_go && data_ok) : byte_av) begin
						nxt_state_ff = spl_pkg::ST_LOAD; // see RULE_01, RULE_20
					end
				// A slave only loads once selected, so a role change
				// cannot inherit a half-started transfer
				end else if (data_ok && cs_act_s) begin
					nxt_state_ff = spl_pkg::ST_LOAD;
				end
			end
			spl_pkg::ST_LOAD: begin
				if (master && stream_en && !stream_go) begin
					nxt_state_ff = spl_pkg::ST_END;                // see RULE_02
				end else if (tx_dis) begin
					nxt_asm_ff   = 32'h0000_0000; // see RULE_09
					nxt_state_ff = spl_pkg::ST_READY;
				end else if (byte_idx_ff == nbytes) begin
					nxt_state_ff = spl_pkg::ST_READY;
				end else if (tx_left_ff != 3'h0) begin
					// One byte a cycle, least significant first
					nxt_asm_ff[{byte_idx_ff[1:0], 3'b000} +: 8] =
						tx_word_ff[7:0]; // see RULE_08
					nxt_tx_word_ff  = {8'h00, tx_word_ff[31:8]};
					nxt_tx_left_ff  = tx_left_ff - 3'h1;
					nxt_byte_idx_ff = byte_idx_ff + 3'h1;
				end else if (!tx_f.empty) begin
					tx_f.pop       = 1'b1;
					nxt_tx_word_ff = tx_f.head;
					nxt_tx_left_ff = spl_pkg::WORD_BYTES;
				end
			end
			spl_pkg::ST_READY: begin
				nxt_bit_cnt_ff = 6'h00;
				nxt_out_cnt_ff = 6'h00;
				nxt_rx_word_ff = 32'h0000_0000; // see RULE_07
				nxt_div_cnt_ff = 32'h0000_0000;
				// Master waits for its select to pass the synchroniser so
				// the first slave bit is not a stale pre-select level
				nxt_cs_n_ff = master ? 1'b0 : cs_n_ff;
				if (cs_act_s) begin
					nxt_state_ff = spl_pkg::ST_SHIFT;
				end
			end
			spl_pkg::ST_SHIFT: begin
				if (master && stream_en && !stream_go) begin
					nxt_state_ff = spl_pkg::ST_END;                // see RULE_02
				end else if (!master && !cs_act_s) begin
					nxt_state_ff = spl_pkg::ST_IDLE;
				end else if (bit_cnt_ff == len_eff &&
					(!master || sclk_ff == cpol)) begin
					nxt_state_ff = spl_pkg::ST_FIN;
				end else begin
					if (master) begin
						nxt_div_cnt_ff = (div_cnt_ff ==
							div_eff - 32'h0000_0001) ? 32'h0000_0000 :
							div_cnt_ff + 32'h0000_0001;
						if (tick) begin
							nxt_sclk_ff = !sclk_ff; // see RULE_19
						end
					end
					// Same edge pair moves one bit each way
					if (is_sample && bit_cnt_ff < len_eff) begin
						nxt_rx_word_ff[bit_pos(bit_cnt_ff, len_eff,
							lsb_first)] = rx_bit; // see RULE_18
						nxt_bit_cnt_ff = bit_cnt_ff + 6'h01;
					end
					if (is_drive && bit_cnt_ff != 6'h00) begin
						nxt_out_cnt_ff = bit_cnt_ff;
					end
				end
			end
			spl_pkg::ST_FIN: begin
				nxt_byte_idx_ff = 3'h0;
				nxt_asm_ff      = 32'h0000_0000;
				if (!rx_dis && drain_left_ff != 3'h0 && master) begin
					nxt_state_ff = spl_pkg::ST_FIN;
				end else begin
					handoff_c = !rx_dis && drain_left_ff == 3'h0; // see RULE_14
					drop_c    = !rx_dis && drain_left_ff != 3'h0;
					if (!master) begin
						nxt_state_ff = spl_pkg::ST_IDLE;
					end else if (stream_en) begin
						nxt_state_ff = stream_go ? spl_pkg::ST_LOAD :
							spl_pkg::ST_END; // see RULE_21
					end else if (txn_left_ff > 8'h01) begin
						nxt_txn_left_ff = txn_left_ff - 8'h01;   // see RULE_20
						nxt_state_ff    = spl_pkg::ST_LOAD;
					end else begin
						nxt_state_ff = spl_pkg::ST_END;
					end
				end
			end
			spl_pkg::ST_END: begin
				nxt_cs_n_ff  = 1'b1;
				nxt_sclk_ff  = cpol;
				nxt_state_ff = spl_pkg::ST_IDLE;
			end
			default: begin
				nxt_state_ff = spl_pkg::ST_IDLE;
			end
		endcase
		nxt_txbit_ff = tx_dis ? 1'b0 :
			nxt_asm_ff[bit_pos(nxt_out_cnt_ff, len_eff, lsb_first)]; // see RULE_12
		nxt_master_oe_ff = master;
		nxt_miso_oe_ff   = !master && cs_act_s;
	end

	// Receive drain: bytes into a 32-bit packer, then the store
	always_comb begin
		nxt_drain_ff      = drain_ff;
		nxt_drain_left_ff = drain_left_ff;
		nxt_pack_ff       = pack_ff;
		nxt_pack_fill_ff  = pack_fill_ff;
		rx_f.push         = 1'b0;
		rx_f.wdata        = {drain_ff[7:0], pack_ff};
		if (handoff_c) begin
			nxt_drain_ff      = rx_word_ff;
			nxt_drain_left_ff = nbytes; // see RULE_07
		end else if (drain_left_ff != 3'h0) begin
			if (pack_fill_ff == 2'h3) begin
				// Store full stalls the drain; master waits on it
				if (!rx_f.full) begin
					rx_f.push         = 1'b1; // see RULE_10
					nxt_pack_fill_ff  = 2'h0;
					nxt_drain_ff      = {8'h00, drain_ff[31:8]};
					nxt_drain_left_ff = drain_left_ff - 3'h1;
				end
			end else begin
				nxt_pack_ff[{pack_fill_ff, 3'b000} +: 8] = drain_ff[7:0];
				nxt_pack_fill_ff  = pack_fill_ff + 2'h1;
				nxt_drain_ff      = {8'h00, drain_ff[31:8]};
				nxt_drain_left_ff = drain_left_ff - 3'h1;
			end
		end
	end

	// Register port
	always_comb begin
		status = 8'h00;
		status[spl_pkg::ST_BUSY]     = (state_ff != spl_pkg::ST_IDLE);
		status[spl_pkg::ST_CS_ACT]   = !cs_n_ff;
		status[spl_pkg::ST_TX_EMPTY] = tx_f.empty;
		status[spl_pkg::ST_TX_FULL]  = tx_f.full;
		status[spl_pkg::ST_RX_EMPTY] = rx_f.empty;
		status[spl_pkg::ST_RX_FULL]  = rx_f.full;
		status[spl_pkg::ST_TX_OVF]   = tx_ovf_ff;
		status[spl_pkg::ST_RX_OVF]   = rx_ovf_ff;
		tx_f.push  = reg_wr_in && reg_addr_in == spl_pkg::ADDR_TX_DATA;
		tx_f.wdata = cfg_ff[spl_pkg::BIT_TX_SWAP] ?
			bswap(reg_wdata_in) : reg_wdata_in; // see RULE_11
		rx_f.pop   = reg_rd_in && reg_addr_in == spl_pkg::ADDR_RX_DATA;
		nxt_clk_div_ff = clk_div_ff;
		nxt_cfg_ff     = cfg_ff;
		nxt_tx_ovf_ff  = tx_ovf_ff;
		nxt_rx_ovf_ff  = rx_ovf_ff;
		if (reg_wr_in && reg_addr_in == spl_pkg::ADDR_CLK_DIV) begin
			nxt_clk_div_ff = reg_wdata_in;
		end
		if (reg_wr_in && reg_addr_in == spl_pkg::ADDR_CONFIG1) begin
			nxt_cfg_ff = reg_wdata_in & spl_pkg::CONFIG1_MASK;
		end
		if (reg_wr_in && reg_addr_in == spl_pkg::ADDR_STATUS) begin
			nxt_tx_ovf_ff = tx_ovf_ff && !reg_wdata_in[spl_pkg::ST_TX_OVF];
			nxt_rx_ovf_ff = rx_ovf_ff && !reg_wdata_in[spl_pkg::ST_RX_OVF];
		end
		// Set beats clear in the same cycle
		if (tx_f.push && tx_f.full) begin
			nxt_tx_ovf_ff = 1'b1;
		end
		if (drop_c) begin
			nxt_rx_ovf_ff = 1'b1;
		end
		nxt_rdata_ff = 32'h0000_0000;
		if (reg_rd_in) begin
			case (reg_addr_in)
				spl_pkg::ADDR_CLK_DIV: nxt_rdata_ff = clk_div_ff;
				spl_pkg::ADDR_CONFIG1: nxt_rdata_ff = cfg_ff;
				spl_pkg::ADDR_STATUS:  nxt_rdata_ff = {24'h00_0000, status};
				spl_pkg::ADDR_RX_DATA: begin
					if (!rx_f.empty) begin
						nxt_rdata_ff = cfg_ff[spl_pkg::BIT_RX_SWAP] ?
							bswap(rx_f.head) : rx_f.head; // see RULE_10
					end
				end
				default: nxt_rdata_ff = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk_sys_in or negedge rst_n) begin
		if (!rst_n) begin
			clk_div_ff    <= spl_pkg::RST_CLK_DIV;
			cfg_ff        <= spl_pkg::RST_CONFIG1; // see RULE_09
			rdata_ff      <= 32'h0000_0000;
			tx_ovf_ff     <= 1'b0;
			rx_ovf_ff     <= 1'b0;
			state_ff      <= spl_pkg::ST_IDLE;
			asm_ff        <= 32'h0000_0000;
			rx_word_ff    <= 32'h0000_0000;
			byte_idx_ff   <= 3'h0;
			bit_cnt_ff    <= 6'h00;
			out_cnt_ff    <= 6'h00;
			div_cnt_ff    <= 32'h0000_0000;
			sclk_ff       <= 1'b0;
			cs_n_ff       <= 1'b1;
			txbit_ff      <= 1'b0;
			txn_left_ff   <= 8'h00;
			tx_word_ff    <= 32'h0000_0000;
			tx_left_ff    <= 3'h0;
			drain_ff      <= 32'h0000_0000;
			drain_left_ff <= 3'h0;
			pack_ff       <= 24'h00_0000;
			pack_fill_ff  <= 2'h0;
			master_oe_ff  <= 1'b0;
			miso_oe_ff    <= 1'b0;
		end else begin
			clk_div_ff    <= nxt_clk_div_ff;
			cfg_ff        <= nxt_cfg_ff;
			rdata_ff      <= nxt_rdata_ff;
			tx_ovf_ff     <= nxt_tx_ovf_ff;
			rx_ovf_ff     <= nxt_rx_ovf_ff;
			state_ff      <= nxt_state_ff;
			asm_ff        <= nxt_asm_ff;
			rx_word_ff    <= nxt_rx_word_ff;
			byte_idx_ff   <= nxt_byte_idx_ff;
			bit_cnt_ff    <= nxt_bit_cnt_ff;
			out_cnt_ff    <= nxt_out_cnt_ff;
			div_cnt_ff    <= nxt_div_cnt_ff;
			sclk_ff       <= nxt_sclk_ff;
			cs_n_ff       <= nxt_cs_n_ff;
			txbit_ff      <= nxt_txbit_ff;
			txn_left_ff   <= nxt_txn_left_ff;
			tx_word_ff    <= nxt_tx_word_ff;
			tx_left_ff    <= nxt_tx_left_ff;
			drain_ff      <= nxt_drain_ff;
			drain_left_ff <= nxt_drain_left_ff;
			pack_ff       <= nxt_pack_ff;
			pack_fill_ff  <= nxt_pack_fill_ff;
			master_oe_ff  <= nxt_master_oe_ff;
			miso_oe_ff    <= nxt_miso_oe_ff;
		end
	end

	assign reg_rdata_out = rdata_ff;
	assign sclk_out      = sclk_ff;
	assign sclk_oe_out   = master_oe_ff;
	assign cs_n_out      = cs_n_ff;
	assign cs_n_oe_out   = master_oe_ff;
	assign mosi_out      = txbit_ff;
	assign mosi_oe_out   = master_oe_ff;
	assign miso_out      = txbit_ff;
	assign miso_oe_out   = miso_oe_ff;
endmodule // spl_link

// ===== verilog/spl_pkg.sv
// Purpose: Shared constants and types of the serial link block
// Assumes: 32-bit register port, byte offsets
// Notes:   Reserved config bits 9-11 and 31 read as zero; 28-30 read back as written
package spl_pkg;
	// Register byte offsets
	localparam logic [7:0]  ADDR_CLK_DIV = 8'h00;
	localparam logic [7:0]  ADDR_TX_DATA = 8'h04;
	localparam logic [7:0]  ADDR_RX_DATA = 8'h08;
	localparam logic [7:0]  ADDR_STATUS  = 8'h0C;
	localparam logic [7:0]  ADDR_CONFIG1 = 8'h10;
	// Reset values and writable mask
	localparam logic [31:0] RST_CLK_DIV  = 32'h0000_0002;
	localparam logic [31:0] RST_CONFIG1  = 32'h0010_8100;
	localparam logic [31:0] CONFIG1_MASK = 32'h7FFF_F1FF;
	// Primary configuration field positions
	localparam int unsigned BIT_CPHA      = 0;
	localparam int unsigned BIT_CPOL      = 1;
	localparam int unsigned BIT_ROLE      = 2;
	localparam int unsigned BIT_RX_DIS    = 3;
	localparam int unsigned BIT_LOOP      = 4;
	localparam int unsigned BIT_LSB_FIRST = 5;
	localparam int unsigned BIT_TX_SWAP   = 6;
	localparam int unsigned BIT_RX_SWAP   = 7;
	localparam int unsigned BIT_TX_DIS    = 8;
	localparam int unsigned LEN_LO        = 12;
	localparam int unsigned LEN_HI        = 17;
	localparam int unsigned BIT_STREAM_EN = 18;
	localparam int unsigned BIT_STREAM_GO = 19;
	localparam int unsigned CNT_LO        = 20;
	localparam int unsigned CNT_HI        = 27;
	// Status field positions
	localparam int unsigned ST_BUSY     = 0;
	localparam int unsigned ST_CS_ACT   = 1;
	localparam int unsigned ST_TX_EMPTY = 2;
	localparam int unsigned ST_TX_FULL  = 3;
	localparam int unsigned ST_RX_EMPTY = 4;
	localparam int unsigned ST_RX_FULL  = 5;
	localparam int unsigned ST_TX_OVF   = 6;
	localparam int unsigned ST_RX_OVF   = 7;
	// Limits
	localparam logic [31:0] DIV_MIN  = 32'h0000_0002;
	localparam logic [5:0]  LEN_MIN  = 6'h03;
	localparam logic [5:0]  LEN_MAX  = 6'h20;
	localparam logic [2:0]  WORD_BYTES = 3'h4;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_LOAD  = 3'b001,
		ST_READY = 3'b010,
		ST_SHIFT = 3'b011,
		ST_FIN   = 3'b100,
		ST_END   = 3'b101
	} spl_state_t;
endpackage
